/* core/bit_sync.sv */
// Two-stage synchroniser for a level from outside the pclk domain
`timescale 1ns/1ns
module bit_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);

	logic meta;

	// First stage is read by the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : bit_sync

/* core/clk_sel_pkg.sv */
// Constants, types and register map of the reference clock selector
package clk_sel_pkg;

	// ****************************************************************
	// Summary of operation
	// - In automatic mode all reference inputs are watched on every clock.
	// - A valid input replaces the internal crystal as the clock source.
	// - Loss of the reference in use falls back to another valid input, else to internal master clock.
	// - The preferred input stays the source while it carries a valid signal.
	// - Without the preferred input, the others are tried in turn, first valid wins.
	// - With no valid input at all, internal master operation is taken automatically.
	// - Each input reports no lock, lock, or lock and synchronous.
	// - Forced internal setting ignores every external reference.
	// - Status shows coarse rate, MADI frame format and channel count.
	// ****************************************************************

	// ****************************************************************
	// Inputs and sources
	// ****************************************************************
	localparam int NUM_IN = 4;
	localparam logic [1:0] IN_MADI = 2'h0;
	localparam logic [1:0] IN_WORD = 2'h1;
	localparam logic [1:0] IN_AES = 2'h2;
	localparam logic [1:0] IN_SYNC = 2'h3;

	// ****************************************************************
	// Register offsets and fields
	// ****************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INT_PERIOD = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_CUR_PERIOD = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	localparam int STAT_MASTER_BIT = 8;
	localparam int STAT_SRC_LSB = 9;
	localparam int STAT_RATE_LSB = 11;
	localparam int STAT_FRAME_BIT = 13;
	localparam int STAT_CH_BIT = 14;
	localparam int IRQ_W = 5;
	localparam int IRQ_SRC_BIT = 0;
	localparam int IRQ_LOCK_LSB = 1;

	// ****************************************************************
	// Measurement counts, in pclk cycles; hysteresis counts in reference periods
	// ****************************************************************
	localparam logic [15:0] PER_MIN = 16'h0004;
	localparam logic [15:0] PER_MAX = 16'h0400;
	localparam logic [15:0] INT_PERIOD_RST = 16'h01a1;
	localparam logic [15:0] SYNC_TOL = 16'h0002;
	localparam logic [2:0] LOCK_HYST = 3'h4;
	localparam logic [2:0] SYNC_HYST = 3'h4;
	localparam logic [15:0] RATE_SINGLE_MIN = 16'h0168;
	localparam logic [15:0] RATE_DOUBLE_MIN = 16'h00b4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {CLK_NO_LOCK, CLK_LOCK, CLK_SYNC} clk_state_e;
	typedef enum logic [1:0] {RATE_NONE, RATE_SINGLE, RATE_DOUBLE, RATE_QUAD} rate_e;
	typedef enum logic {SEL_MASTER, SEL_SLAVE} sel_state_e;

	typedef struct packed {
		logic [1:0] pref;
		logic auto_en;
	} ctrl_s;

	typedef struct packed {
		logic lock;
		logic [15:0] period;
		logic tick;
	} meas_s;

	localparam ctrl_s CTRL_RST = '{pref: 2'h0, auto_en: 1'b1};

endpackage : clk_sel_pkg

/* core/clock_source_select.sv */
// Reference clock selector with lock, sync and rate supervision
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module clock_source_select (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic madi_ref,
	input wire logic word_ref,
	input wire logic aes_ref,
	input wire logic sync_ref,
	input wire logic madi_frame_96k,
	input wire logic madi_ch56,
	output logic clk_master,
	output logic [1:0] clk_src,
	output logic irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [3:0] refs;
	clk_sel_pkg::meas_s meas [clk_sel_pkg::NUM_IN];
	logic [3:0] lock_v;
	logic [3:0] sync_v;
	logic [3:0] lock_chg;
	logic [1:0] in_state [clk_sel_pkg::NUM_IN];
	logic frame_96k_s;
	logic ch56_s;

	clk_sel_pkg::ctrl_s ctrl;
	clk_sel_pkg::ctrl_s next_ctrl;
	logic [15:0] int_period;
	logic [15:0] next_int_period;
	logic [4:0] irq_stat;
	logic [4:0] next_irq_stat;
	logic [4:0] irq_mask;
	logic [4:0] next_irq_mask;
	logic next_irq;

	clk_sel_pkg::sel_state_e state;
	clk_sel_pkg::sel_state_e next_state;
	logic [1:0] next_src;
	logic next_master;
	logic src_chg;

	logic [15:0] act_period;
	logic [1:0] rate;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic setup;
	logic wr;
	logic mapped;
	logic [31:0] rd;

	assign refs = {sync_ref, aes_ref, word_ref, madi_ref};

	// ****************************************************************
	// Per-input monitors and sync judgement
	// ****************************************************************
	for (genvar i = 0; i < clk_sel_pkg::NUM_IN; i++) begin : g_in
		logic [2:0] sync_cnt;
		logic [2:0] next_sync_cnt;
		logic sync_q;
		logic next_sync;
		logic lock_d;
		logic [15:0] diff;

		input_monitor u_mon (
			.pclk(pclk),
			.presetn(presetn),
			.ref_in(refs[i]),
			.meas(meas[i])
		);

		// Up/down count of matching periods gives hysteresis both ways
		always_comb begin
			if (meas[i].period >= act_period) begin
				diff = meas[i].period - act_period;
			end else begin
				diff = act_period - meas[i].period;
			end
			next_sync_cnt = sync_cnt;
			next_sync = sync_q;
			if (!meas[i].lock) begin
				next_sync_cnt = 3'h0;
				next_sync = 1'b0;
			end else if (meas[i].tick) begin
				if (diff <= clk_sel_pkg::SYNC_TOL) begin
					if (sync_cnt != clk_sel_pkg::SYNC_HYST) begin
						next_sync_cnt = sync_cnt + 3'h1;
					end
				end else if (sync_cnt != 3'h0) begin
					next_sync_cnt = sync_cnt - 3'h1;
				end
				if (next_sync_cnt == clk_sel_pkg::SYNC_HYST) begin
					next_sync = 1'b1;
				end else if (next_sync_cnt == 3'h0) begin
					next_sync = 1'b0;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sync_cnt <= 3'h0;
				sync_q <= 1'b0;
				lock_d <= 1'b0;
			end else begin
				sync_cnt <= next_sync_cnt;
				sync_q <= next_sync;
				lock_d <= meas[i].lock;
			end
		end

		assign lock_v[i] = meas[i].lock;
		assign sync_v[i] = sync_q;
		assign lock_chg[i] = lock_d ^ meas[i].lock;

		// Three-way clock state per input
		assign in_state[i] = !meas[i].lock ? clk_sel_pkg::CLK_NO_LOCK :
			(sync_q ? clk_sel_pkg::CLK_SYNC : clk_sel_pkg::CLK_LOCK);
	end

	// MADI format pins come from the deframer clock domain
	bit_sync u_sync_frame (
		.pclk(pclk),
		.presetn(presetn),
		.d(madi_frame_96k),
		.q(frame_96k_s)
	);

	bit_sync u_sync_ch (
		.pclk(pclk),
		.presetn(presetn),
		.d(madi_ch56),
		.q(ch56_s)
	);

	// ****************************************************************
	// Active period and coarse rate
	// ****************************************************************
	// Master compares against the crystal divider, slave against its source
	always_comb begin
		if (state == clk_sel_pkg::SEL_MASTER) begin
			act_period = int_period;
		end else begin
			act_period = meas[clk_src].period;
		end
		if (act_period >= clk_sel_pkg::RATE_SINGLE_MIN) begin
			rate = clk_sel_pkg::RATE_SINGLE;
		end else if (act_period >= clk_sel_pkg::RATE_DOUBLE_MIN) begin
			rate = clk_sel_pkg::RATE_DOUBLE;
		end else if (act_period != 16'h0000) begin
			rate = clk_sel_pkg::RATE_QUAD;
		end else begin
			rate = clk_sel_pkg::RATE_NONE;
		end
	end

	// ****************************************************************
	// Source selection
	// ****************************************************************
	// Re-evaluated every cycle, so a lost source is left at once
	always_comb begin
		logic found;
		logic [1:0] cand;
		found = 1'b0;
		cand = 2'h0;
		next_state = state;
		next_src = clk_src;
		if (!ctrl.auto_en) begin
			next_state = clk_sel_pkg::SEL_MASTER;
		end else if (lock_v[ctrl.pref]) begin
			next_state = clk_sel_pkg::SEL_SLAVE;
			next_src = ctrl.pref;
		end else begin
			// Fixed order after the preferred input keeps the choice predictable
			for (int k = 1; k < clk_sel_pkg::NUM_IN; k++) begin
				cand = ctrl.pref + 2'(k);
				if (!found && lock_v[cand]) begin
					found = 1'b1;
					next_src = cand;
				end
			end
			if (found) begin
				next_state = clk_sel_pkg::SEL_SLAVE;
			end else begin
				next_state = clk_sel_pkg::SEL_MASTER;
			end
		end
		next_master = (next_state == clk_sel_pkg::SEL_MASTER);
		src_chg = (next_state != state) ||
			((next_state == clk_sel_pkg::SEL_SLAVE) && (next_src != clk_src));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= clk_sel_pkg::SEL_MASTER;
			clk_src <= clk_sel_pkg::IN_MADI;
			clk_master <= 1'b1;
		end else begin
			state <= next_state;
			clk_src <= next_src;
			clk_master <= next_master;
		end
	end

	// ****************************************************************
	// APB decode and read data
	// ****************************************************************
	// Read data is captured in the setup cycle so every output is a flop
	always_comb begin
		setup = psel & ~penable;
		wr = psel & penable & pready & pwrite & ~pslverr;
		mapped = 1'b1;
		rd = 32'h0000_0000;
		unique case (paddr)
			clk_sel_pkg::OFF_CTRL: begin
				rd[2:0] = ctrl;
			end
			clk_sel_pkg::OFF_INT_PERIOD: begin
				rd[15:0] = int_period;
			end
			clk_sel_pkg::OFF_STATUS: begin
				for (int n = 0; n < clk_sel_pkg::NUM_IN; n++) begin
					rd[2 * n +: 2] = in_state[n];
				end
				rd[clk_sel_pkg::STAT_MASTER_BIT] = clk_master;
				rd[clk_sel_pkg::STAT_SRC_LSB +: 2] = clk_src;
				rd[clk_sel_pkg::STAT_RATE_LSB +: 2] = rate;
				rd[clk_sel_pkg::STAT_FRAME_BIT] = frame_96k_s;
				rd[clk_sel_pkg::STAT_CH_BIT] = ch56_s;
			end
			clk_sel_pkg::OFF_CUR_PERIOD: begin
				rd[15:0] = act_period;
			end
			clk_sel_pkg::OFF_IRQ_STAT: begin
				rd[4:0] = irq_stat;
			end
			clk_sel_pkg::OFF_IRQ_MASK: begin
				rd[4:0] = irq_mask;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		next_pready = setup;
		next_pslverr = setup & ~mapped;
		next_prdata = setup ? rd : prdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// Control, mask and event registers
	// ****************************************************************
	// Hardware events win over a clearing write in the same cycle
	always_comb begin
		logic [4:0] events;
		events = 5'h00;
		events[clk_sel_pkg::IRQ_SRC_BIT] = src_chg;
		events[clk_sel_pkg::IRQ_LOCK_LSB +: 4] = lock_chg;
		next_ctrl = ctrl;
		next_int_period = int_period;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		if (wr) begin
			unique case (paddr)
				clk_sel_pkg::OFF_CTRL: begin
					next_ctrl = pwdata[2:0];
				end
				clk_sel_pkg::OFF_INT_PERIOD: begin
					next_int_period = pwdata[15:0];
				end
				clk_sel_pkg::OFF_IRQ_STAT: begin
					next_irq_stat = irq_stat & ~pwdata[4:0];
				end
				clk_sel_pkg::OFF_IRQ_MASK: begin
					next_irq_mask = pwdata[4:0];
				end
				default: begin
				end
			endcase
		end
		next_irq_stat = next_irq_stat | events;
		next_irq = |(irq_stat & irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= clk_sel_pkg::CTRL_RST;
			int_period <= clk_sel_pkg::INT_PERIOD_RST;
			irq_mask <= 5'h00;
			irq_stat <= 5'h00;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			int_period <= next_int_period;
			irq_mask <= next_irq_mask;
			irq_stat <= next_irq_stat;
			irq <= next_irq;
		end
	end

endmodule : clock_source_select

/* core/input_monitor.sv */
// Edge spacing meter and lock detector for one reference input
`timescale 1ns/1ns
module input_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ref_in,
	output clk_sel_pkg::meas_s meas
);

	logic ref_s;
	logic prev;
	logic [15:0] cnt;
	logic [2:0] good_cnt;
	logic next_prev;
	logic [15:0] next_cnt;
	logic [2:0] next_good_cnt;
	clk_sel_pkg::meas_s next_meas;
	logic rise;
	logic good;

	bit_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(ref_in),
		.q(ref_s)
	);

	// Count cycles between rising edges; holds just past PER_MAX, never wraps
	always_comb begin
		next_prev = ref_s;
		rise = ref_s & ~prev;
		good = rise && (cnt >= clk_sel_pkg::PER_MIN) && (cnt <= clk_sel_pkg::PER_MAX);
		next_meas = meas;
		next_meas.tick = good;
		next_good_cnt = good_cnt;
		next_cnt = (cnt > clk_sel_pkg::PER_MAX) ? cnt : cnt + 16'h0001;
		if (rise) begin
			next_cnt = 16'h0001;
			if (good) begin
				next_meas.period = cnt;
				if (good_cnt != clk_sel_pkg::LOCK_HYST) begin
					next_good_cnt = good_cnt + 3'h1;
				end
				// Several clean periods needed, so one glitch cannot lock
				if (next_good_cnt == clk_sel_pkg::LOCK_HYST) begin
					next_meas.lock = 1'b1;
				end
			end else begin
				next_good_cnt = 3'h0;
				next_meas.lock = 1'b0;
			end
		end else if (cnt > clk_sel_pkg::PER_MAX) begin
			// Missing edges drop lock at once
			next_good_cnt = 3'h0;
			next_meas.lock = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b0;
			cnt <= 16'h0000;
			good_cnt <= 3'h0;
			meas <= '0;
		end else begin
			prev <= next_prev;
			cnt <= next_cnt;
			good_cnt <= next_good_cnt;
			meas <= next_meas;
		end
	end

endmodule : input_monitor

/* test/clock_source_select_assertions.sv */
// Port checker for the reference clock selector
`timescale 1ns/1ns
module clock_source_select_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic madi_ref,
	input wire logic word_ref,
	input wire logic aes_ref,
	input wire logic sync_ref,
	input wire logic clk_master,
	input wire logic irq
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	logic [10:0] quiet;
	logic [3:0] refs_q;
	logic [15:0] per;
	wire [3:0] refs = {madi_ref, word_ref, aes_ref, sync_ref};

	// Cycles since any reference moved; saturates so it never wraps to busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet <= 11'h0;
			refs_q <= 4'h0;
			per <= clk_sel_pkg::INT_PERIOD_RST;
		end else begin
			refs_q <= refs;
			quiet <= (refs_q != refs) ? 11'h0 : quiet + 11'(quiet != 11'h7ff);
			if (psel && penable && pready && pwrite && paddr == clk_sel_pkg::OFF_INT_PERIOD)
				per <= pwdata[15:0];
		end
	end

	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	property p_zero_wait;
		s_setup |=> pready;
	endproperty
	property p_one_pulse;
		pready |=> !pready;
	endproperty
	property p_err_ready;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	property p_rd_period;
		s_done ##0 (!pwrite && paddr == clk_sel_pkg::OFF_INT_PERIOD) |-> prdata == {16'h0, per};
	endproperty
	property p_irq_off;
		s_done ##0 (pwrite && paddr == clk_sel_pkg::OFF_IRQ_MASK && pwdata[4:0] == 5'h0)
			|-> ##2 !irq;
	endproperty
	property p_forced;
		s_done ##0 (pwrite && paddr == clk_sel_pkg::OFF_CTRL && !pwdata[0]) |-> ##[1:3] clk_master;
	endproperty
	property p_idle_master;
		quiet >= 11'h44c |-> clk_master;
	endproperty
	property p_leave_master;
		$fell(clk_master) |-> quiet < 11'h44c;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("pready late");
	a_one_pulse: assert property (p_one_pulse) else $error("pready held");
	a_err_ready: assert property (p_err_ready) else $error("bad error response");
	a_rd_period: assert property (p_rd_period) else $error("period readback");
	a_irq_off: assert property (p_irq_off) else $error("irq with mask clear");
	a_forced: assert property (p_forced) else $error("forced not master");
	a_idle_master: assert property (p_idle_master) else $error("no master");
	a_leave_master: assert property (p_leave_master) else $error("slave w/o input");
endmodule : clock_source_select_assertions

bind clock_source_select clock_source_select_assertions chk (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .madi_ref, .word_ref, .aes_ref,
	.sync_ref, .clk_master, .irq);

/* test/ref_sources.sv */
// Behavioural model of the upstream audio clock sources
`timescale 1ns/1ns
module ref_sources (
	input wire logic [3:0] on,
	output logic [3:0] refs
);
	// ****************************************************************
	// Sources
	// ****************************************************************
	// 400 ns frame clock per source, skewed phases; a dead source idles low
	for (genvar i = 0; i < 4; i++) begin : g_src
		initial begin
			refs[i] = 1'b0;
			#(37 * i + 11);
			forever begin
				#200 refs[i] = on[i] ? ~refs[i] : 1'b0;
			end
		end
	end
endmodule : ref_sources

/* test/test_audio_clock_source_select.sv */
// Self-checking bench for the reference clock selector
`timescale 1ns/1ns
module test_audio_clock_source_select;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic clk_master, madi_frame_96k, madi_ch56, err;
	logic [1:0] clk_src, p;
	logic [3:0] on, refs;
	logic [7:0] paddr;
	logic [15:0] per;
	logic [31:0] pwdata, prdata, rd;
	int failures, checked, seed;

	clock_source_select dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .madi_ref(refs[0]), .word_ref(refs[1]),
		.aes_ref(refs[2]), .sync_ref(refs[3]), .madi_frame_96k, .madi_ch56,
		.clk_master, .clk_src, .irq);
	ref_sources src (.on, .refs);

	// ****************************************************************
	// Tasks and expectations
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits on pready, only the watchdog ends a hung wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Loss of lock takes over a thousand cycles, hence the generous bound
	task automatic wait_sel(input logic m, input logic [1:0] s);
		int n;
		n = 0;
		while ((clk_master !== m || (!m && clk_src !== s)) && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		check(clk_master, m);
		if (!m) check(clk_src, s);
	endtask : wait_sel

	function automatic logic [1:0] rate_of(input logic [15:0] t);
		return (t >= 16'h0168) ? 2'h1 : (t >= 16'h00b4) ? 2'h2 : 2'h3;
	endfunction : rate_of

	function automatic logic [31:0] exp_stat(input logic [7:0] st, input logic m,
		input logic [1:0] s, input logic [1:0] r);
		return {17'h0, madi_ch56, madi_frame_96k, r, s, m, st};
	endfunction : exp_stat

	task automatic results;
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		seed = 32'h885a7214;
		failures = 0;
		checked = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, on} <= '0;
		madi_frame_96k <= 1'($random(seed));
		madi_ch56 <= 1'($random(seed));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset state and an unmapped place
		check(clk_master, 1'b1);
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		check(rd, 32'h1a1);
		apb(1'b0, 8'h18, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		// Random internal periods, seen through the current period register and status rate while master
		repeat (3) begin
			per = 16'h00b4 + 16'($random(seed) & 32'hff);
			apb(1'b1, 8'h04, {16'h0, per});
			apb(1'b0, 8'h0c, 32'h0);
			check(rd, {16'h0, per});
			apb(1'b0, 8'h08, 32'h0);
			check(rd & 32'hfffff9ff, exp_stat(8'h00, 1'b1, 2'h0, rate_of(per)));
		end
		// Word clock alone stands in for the missing preferred input
		apb(1'b1, 8'h14, 32'h1);
		on <= 4'h2;
		wait_sel(1'b0, 2'h1);
		repeat (3) @(posedge pclk);
		check(irq, 1'b1);
		apb(1'b1, 8'h10, 32'h1f);
		repeat (2) @(posedge pclk);
		check(irq, 1'b0);
		apb(1'b1, 8'h14, 32'h0);
		// Every preference in turn, then all inputs settle to sync
		on <= 4'hf;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, {29'h0, 2'(i), 1'b1});
			wait_sel(1'b0, 2'(i));
		end
		repeat (200) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		check(rd, exp_stat(8'haa, 1'b0, 2'h3, 2'h3));
		// Preferred input dies and returns
		repeat (2) begin
			p = 2'($random(seed));
			apb(1'b1, 8'h00, {29'h0, p, 1'b1});
			wait_sel(1'b0, p);
			on <= 4'hf & ~(4'h1 << p);
			wait_sel(1'b0, p + 2'h1);
			on <= 4'hf;
			wait_sel(1'b0, p);
		end
		// Forced internal clock ignores live references
		apb(1'b1, 8'h00, 32'h0);
		wait_sel(1'b1, 2'h0);
		repeat (200) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		check(rd & 32'hfffff9ff, exp_stat(8'h55, 1'b1, 2'h0, rate_of(per)));
		apb(1'b1, 8'h00, 32'h1);
		wait_sel(1'b0, 2'h0);
		// Every reference lost: back to the crystal
		on <= 4'h0;
		wait_sel(1'b1, 2'h0);
		// Long silence so the idle-master property is really exercised
		repeat (200) @(posedge pclk);
		check(clk_master, 1'b1);
		results();
	end

	// Watchdog, well beyond the few thousand cycles the run needs
	initial begin
		#1000000;
		failures++;
		results();
	end
endmodule : test_audio_clock_source_select
